//--- seq_pkg.sv
`default_nettype none

package seq_pkg;

  // Register width and number of filter positions
  localparam int COND_W = 16;

  // Condition bit positions
  localparam int COND_RSVD_LO = 0;
  localparam int COND_OUTPUT_ON = 1;
  localparam int COND_EXT_JUNCTION_VALID = 2;
  localparam int COND_SOURCE_CHANGE = 3;
  localparam int COND_INT_JUNCTION_VALID = 4;
  localparam int COND_RSVD_MID = 5;
  localparam int COND_AMP_OSCILLATING = 6;
  localparam int COND_VOLTAGE_LIMITING = 7;
  localparam int COND_CURRENT_LIMITING = 8;
  localparam int COND_CURRENT_INPUT_DETECTED = 9;
  localparam int COND_JUNCTION_SENSOR_CONNECTED = 10;
  localparam int COND_TOP_USED = 10;

  // Reset values of the register bank
  localparam logic [15:0] COND_RST = 16'h0000;
  localparam logic [15:0] EVENT_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;

  // Source change hold time
  localparam longint CLK_HZ = 200_000_000;
  localparam longint SRC_CHG_MS = 500;
  localparam longint SRC_CHG_CYC = SRC_CHG_MS * CLK_HZ / 1000;

  // Transition filter modes; first value is the reset mode
  typedef enum logic [1:0] {
    SEQ_NEVER,
    SEQ_RISE,
    SEQ_FALL,
    SEQ_BOTH
  } seq_filt_mode_t;

  // One error queue entry: error number and message index
  typedef struct packed {
    logic [9:0] num;
    logic [5:0] msg;
  } seq_err_entry_t;

  // Fixed entries
  localparam logic [9:0] ERR_OVF_NUM = 10'h15e;
  localparam logic [5:0] ERR_OVF_MSG = 6'h01;
  localparam logic [9:0] ERR_NONE_NUM = 10'h000;
  localparam logic [5:0] ERR_NONE_MSG = 6'h00;

endpackage : seq_pkg

`default_nettype wire

//--- seq_mem.sv
`default_nettype none

module seq_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Write side
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read side, data one cycle after the strobe
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset so it can map onto block memory
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read-first: a same-address write shows next time
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : seq_mem

`default_nettype wire

//--- seq_status.sv
`default_nettype none

module seq_status #(
  parameter longint SRC_CHG_CYCLES = seq_pkg::SRC_CHG_CYC,
  parameter int OQ_DEPTH = 64,
  parameter int EQ_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Condition pins, asynchronous
  input wire logic i_output_on,
  input wire logic i_ext_junction_valid,
  input wire logic i_int_junction_valid,
  input wire logic i_amp_oscillating,
  input wire logic i_voltage_limiting,
  input wire logic i_current_limiting,
  input wire logic i_current_input_detected,
  input wire logic i_junction_sensor_connected,
  // Output setting changed, one-cycle pulse
  input wire logic i_setting_changed,
  // Transition filter and enable writes, event read-clear
  input wire logic i_filt_wr,
  input wire logic [4:0] i_filt_suffix,
  input wire seq_pkg::seq_filt_mode_t i_filt_mode,
  input wire logic i_ese_wr,
  input wire logic [15:0] i_ese_data,
  input wire logic i_eer_rd,
  // Message handling events
  input wire logic i_cls,
  input wire logic i_msg_received,
  input wire logic i_deadlock,
  input wire logic i_dev_clear,
  input wire logic i_restart,
  // Output queue
  input wire logic i_oq_push,
  input wire logic [7:0] i_oq_data,
  input wire logic i_oq_pop,
  output logic [7:0] o_oq_data,
  output logic o_oq_valid,
  output logic o_oq_full,
  // Error queue
  input wire logic i_err_push,
  input wire seq_pkg::seq_err_entry_t i_err_entry,
  input wire logic i_err_pop,
  output seq_pkg::seq_err_entry_t o_err_entry,
  output logic o_err_valid,
  // Registers and status byte bits
  output logic [15:0] o_condition,
  output logic [15:0] o_ext_event,
  output logic o_ext_summary,
  output logic o_msg_avail,
  output logic o_err_avail
);

  localparam int CW = $clog2(SRC_CHG_CYCLES + 1);
  localparam int OAW = $clog2(OQ_DEPTH);
  localparam int EAW = $clog2(EQ_DEPTH);
  localparam logic [OAW:0] OQ_FULL = (OAW + 1)'(OQ_DEPTH);
  localparam logic [EAW:0] EQ_FULL = (EAW + 1)'(EQ_DEPTH);
  localparam logic [CW-1:0] SRC_LOAD = CW'(SRC_CHG_CYCLES);

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [CW-1:0] src_cnt;
    logic [15:0] cond;
    logic [15:0] eer;
    logic [15:0] ese;
    seq_pkg::seq_filt_mode_t [15:0] mode;
    logic [OAW-1:0] oq_wr;
    logic [OAW-1:0] oq_rd;
    logic [OAW:0] oq_cnt;
    logic oq_pend;
    logic [7:0] oq_data;
    logic oq_valid;
    logic oq_full;
    logic [EAW-1:0] eq_wr;
    logic [EAW-1:0] eq_rd;
    logic [EAW:0] eq_cnt;
    logic eq_pend;
    logic eq_none;
    seq_pkg::seq_err_entry_t eq_data;
    logic eq_valid;
    logic summary;
    logic msg_avail;
    logic err_avail;
  } seq_state_t;

  seq_state_t state_reg;
  seq_state_t state_next;

  // Pin order inside the synchroniser
  logic [7:0] pin_raw;
  assign pin_raw = {i_junction_sensor_connected, i_current_input_detected,
                    i_current_limiting, i_voltage_limiting, i_amp_oscillating,
                    i_int_junction_valid, i_ext_junction_valid, i_output_on};

  // Memory ports
  logic oq_we;
  logic oq_re;
  logic [OAW-1:0] oq_wa;
  logic [7:0] oq_rdata;
  logic eq_we;
  logic eq_re;
  logic [EAW-1:0] eq_wa;
  seq_pkg::seq_err_entry_t eq_wd;
  seq_pkg::seq_err_entry_t eq_rdata;

  // Queue housekeeping terms, output-on rise and event clear base
  logic oq_clr;
  logic oq_pop_ok;
  logic oq_push_ok;
  logic [OAW-1:0] oq_bwr;
  logic [OAW:0] oq_bcnt;
  logic eq_clr;
  logic eq_pop_ok;
  logic eq_push_ok;
  logic eq_ovf;
  logic [EAW-1:0] eq_bwr;
  logic [EAW:0] eq_bcnt;
  logic out_rise;
  logic [15:0] ev_base;

  // Edge decode of one filter position
  function automatic logic edge_hit(input seq_pkg::seq_filt_mode_t mode,
                                    input logic old_v, input logic new_v);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      seq_pkg::SEQ_NEVER: hit = 1'b0;
      seq_pkg::SEQ_RISE: hit = ~old_v & new_v;
      seq_pkg::SEQ_FALL: hit = old_v & ~new_v;
      seq_pkg::SEQ_BOTH: hit = old_v ^ new_v;
    endcase
    return hit;
  endfunction : edge_hit

  // All next-state logic
  always_comb begin
    state_next = state_reg;
    // Two-stage synchroniser on the condition pins
    state_next.sync1 = pin_raw;
    state_next.sync2 = state_reg.sync1;

    // Source change: retriggered hold timer
    out_rise = state_reg.sync2[0] & ~state_reg.cond[seq_pkg::COND_OUTPUT_ON];
    if (out_rise || i_setting_changed) begin
      state_next.src_cnt = SRC_LOAD;
    end else if (state_reg.src_cnt != '0) begin
      state_next.src_cnt = state_reg.src_cnt - 1'b1;
    end

    // Condition register; unused positions stay zero
    state_next.cond = seq_pkg::COND_RST;
    state_next.cond[seq_pkg::COND_OUTPUT_ON] = state_reg.sync2[0];
    state_next.cond[seq_pkg::COND_EXT_JUNCTION_VALID] = state_reg.sync2[1];
    state_next.cond[seq_pkg::COND_SOURCE_CHANGE] = state_next.src_cnt != '0;
    state_next.cond[seq_pkg::COND_INT_JUNCTION_VALID] = state_reg.sync2[2];
    state_next.cond[seq_pkg::COND_AMP_OSCILLATING] = state_reg.sync2[3];
    state_next.cond[seq_pkg::COND_VOLTAGE_LIMITING] = state_reg.sync2[4];
    state_next.cond[seq_pkg::COND_CURRENT_LIMITING] = state_reg.sync2[5];
    state_next.cond[seq_pkg::COND_CURRENT_INPUT_DETECTED] = state_reg.sync2[6];
    state_next.cond[seq_pkg::COND_JUNCTION_SENSOR_CONNECTED] = state_reg.sync2[7];

    // Event register: a filtered edge beats a same-cycle clear
    ev_base = (i_cls || i_restart || i_eer_rd) ? seq_pkg::EVENT_RST : state_reg.eer;
    for (int k = 0; k < seq_pkg::COND_W; k++) begin
      state_next.eer[k] = (ev_base[k] |
          edge_hit(state_reg.mode[k], state_reg.cond[k], state_next.cond[k])) &
          (state_reg.mode[k] != seq_pkg::SEQ_NEVER);
    end

    // Filter mode write; suffixes outside 1..16 are ignored
    if (i_filt_wr && i_filt_suffix != 5'h00 && i_filt_suffix <= 5'h10) begin
      state_next.mode[4'(i_filt_suffix - 5'h01)] = i_filt_mode;
    end
    if (i_ese_wr) begin
      state_next.ese = i_ese_data;
    end
    state_next.summary = |(state_next.eer & state_next.ese);

    // Output queue; a push in a clearing cycle lands after the clear
    oq_clr = i_msg_received | i_deadlock | i_dev_clear | i_restart;
    oq_bwr = oq_clr ? '0 : state_reg.oq_wr;
    oq_bcnt = oq_clr ? '0 : state_reg.oq_cnt;
    oq_pop_ok = i_oq_pop & ~oq_clr & (state_reg.oq_cnt != '0);
    oq_push_ok = i_oq_push & ((oq_bcnt != OQ_FULL) | oq_pop_ok);
    oq_we = oq_push_ok;
    oq_wa = oq_bwr;
    oq_re = oq_pop_ok;
    state_next.oq_wr = oq_bwr + OAW'(oq_push_ok);
    state_next.oq_rd = (oq_clr ? '0 : state_reg.oq_rd) + OAW'(oq_pop_ok);
    state_next.oq_cnt = oq_bcnt + (OAW + 1)'(oq_push_ok) - (OAW + 1)'(oq_pop_ok);
    state_next.oq_pend = oq_pop_ok;
    state_next.oq_valid = state_reg.oq_pend & ~oq_clr;
    state_next.oq_data = state_reg.oq_pend ? oq_rdata : state_reg.oq_data;
    state_next.oq_full = state_next.oq_cnt == OQ_FULL;
    state_next.msg_avail = state_next.oq_cnt != '0;

    // Error queue; only clear-status or restart empties it
    eq_clr = i_cls | i_restart;
    eq_bwr = eq_clr ? '0 : state_reg.eq_wr;
    eq_bcnt = eq_clr ? '0 : state_reg.eq_cnt;
    eq_pop_ok = i_err_pop & ~eq_clr & (state_reg.eq_cnt != '0);
    eq_push_ok = i_err_push & ((eq_bcnt != EQ_FULL) | eq_pop_ok);
    eq_ovf = i_err_push & (eq_bcnt == EQ_FULL) & ~eq_pop_ok;
    eq_we = eq_push_ok | eq_ovf;
    eq_wa = eq_ovf ? eq_bwr - 1'b1 : eq_bwr;
    eq_wd = eq_ovf ? {seq_pkg::ERR_OVF_NUM, seq_pkg::ERR_OVF_MSG} : i_err_entry;
    eq_re = eq_pop_ok;
    state_next.eq_wr = eq_bwr + EAW'(eq_push_ok);
    state_next.eq_rd = (eq_clr ? '0 : state_reg.eq_rd) + EAW'(eq_pop_ok);
    state_next.eq_cnt = eq_bcnt + (EAW + 1)'(eq_push_ok) - (EAW + 1)'(eq_pop_ok);
    state_next.eq_pend = eq_pop_ok;
    // Reading an empty queue answers with the no-error entry
    state_next.eq_none = i_err_pop & ~eq_clr & (state_reg.eq_cnt == '0);
    state_next.eq_valid = (state_reg.eq_pend | state_reg.eq_none) & ~eq_clr;
    if (state_reg.eq_pend) begin
      state_next.eq_data = eq_rdata;
    end else if (state_reg.eq_none) begin
      state_next.eq_data = {seq_pkg::ERR_NONE_NUM, seq_pkg::ERR_NONE_MSG};
    end
    state_next.err_avail = state_next.eq_cnt != '0;
  end

  // All-zero state is the reset value, filters in never mode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Response byte store
  seq_mem #(
    .WIDTH(8),
    .DEPTH(OQ_DEPTH)
  ) u_oq_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(oq_we),
    .i_waddr(oq_wa),
    .i_wdata(i_oq_data),
    .i_re(oq_re),
    .i_raddr(state_reg.oq_rd),
    .o_rdata(oq_rdata)
  );

  // Error entry store
  seq_mem #(
    .WIDTH($bits(seq_pkg::seq_err_entry_t)),
    .DEPTH(EQ_DEPTH)
  ) u_eq_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(eq_we),
    .i_waddr(eq_wa),
    .i_wdata(eq_wd),
    .i_re(eq_re),
    .i_raddr(state_reg.eq_rd),
    .o_rdata(eq_rdata)
  );

  // Outputs come straight from the state register
  assign o_condition = state_reg.cond;
  assign o_ext_event = state_reg.eer;
  assign o_ext_summary = state_reg.summary;
  assign o_msg_avail = state_reg.msg_avail;
  assign o_err_avail = state_reg.err_avail;
  assign o_oq_data = state_reg.oq_data;
  assign o_oq_valid = state_reg.oq_valid;
  assign o_oq_full = state_reg.oq_full;
  assign o_err_entry = state_reg.eq_data;
  assign o_err_valid = state_reg.eq_valid;

  // Cycles since reset release, for pin-latency checks
  logic [1:0] age;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  // Pin to condition bit takes three edges
  property p_out_on;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 |-> o_condition[seq_pkg::COND_OUTPUT_ON] == $past(i_output_on, 3);
  endproperty
  a_out_on: assert property (p_out_on) else $error("output-on bit wrong");
  property p_ext_jv;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 |-> o_condition[2] == $past(i_ext_junction_valid, 3);
  endproperty
  a_ext_jv: assert property (p_ext_jv) else $error("ext junction bit wrong");
  property p_int_jv;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 |-> o_condition[4] == $past(i_int_junction_valid, 3);
  endproperty
  a_int_jv: assert property (p_int_jv) else $error("int junction bit wrong");
  property p_osc;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 && $past(i_amp_oscillating, 3) |-> o_condition[6];
  endproperty
  a_osc: assert property (p_osc) else $error("oscillation bit missed");
  property p_vlim;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 && $past(i_voltage_limiting, 3) |-> o_condition[7];
  endproperty
  a_vlim: assert property (p_vlim) else $error("voltage limit bit missed");
  property p_ilim;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 && $past(i_current_limiting, 3) |-> o_condition[8];
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit bit missed");
  property p_cid;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 && $past(i_current_input_detected, 3) |-> o_condition[9];
  endproperty
  a_cid: assert property (p_cid) else $error("current input bit missed");
  property p_junction_sensor_connected;
    @(posedge i_clk_sys) disable iff (i_rst)
    age == 2'h3 && $past(i_junction_sensor_connected, 3) |-> o_condition[10];
  endproperty
  a_junction_sensor_connected: assert property (p_junction_sensor_connected) else $error("sensor bit missed");
  property p_src_chg;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_setting_changed |=> o_condition[seq_pkg::COND_SOURCE_CHANGE] [*2];
  endproperty
  a_src_chg: assert property (p_src_chg) else $error("source change not held");
  property p_fixed_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_condition[seq_pkg::COND_RSVD_LO] == 1'b0 && o_condition[seq_pkg::COND_RSVD_MID] == 1'b0
        && o_condition[15:seq_pkg::COND_TOP_USED + 1] == '0;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("reserved bit set");
  property p_edge_only;
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_ext_event[1]) |-> $changed(o_condition[1]);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("event without edge");
  property p_never;
    @(posedge i_clk_sys) disable iff (i_rst)
    state_reg.mode[1] == seq_pkg::SEQ_NEVER |=> !o_ext_event[1];
  endproperty
  a_never: assert property (p_never) else $error("never mode event set");
  property p_rise;
    @(posedge i_clk_sys) disable iff (i_rst)
    $past(state_reg.mode[1]) == seq_pkg::SEQ_RISE && $rose(o_condition[1]) |-> o_ext_event[1];
  endproperty
  a_rise: assert property (p_rise) else $error("rise edge missed");
  property p_fall;
    @(posedge i_clk_sys) disable iff (i_rst)
    $past(state_reg.mode[1]) == seq_pkg::SEQ_FALL && $fell(o_condition[1]) |-> o_ext_event[1];
  endproperty
  a_fall: assert property (p_fall) else $error("fall edge missed");
  property p_both;
    @(posedge i_clk_sys) disable iff (i_rst)
    $past(state_reg.mode[1]) == seq_pkg::SEQ_BOTH && $changed(o_condition[1])
        |-> o_ext_event[1];
  endproperty
  a_both: assert property (p_both) else $error("both edge missed");
  property p_oq_read;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_oq_pop && o_msg_avail && !oq_clr) ##1 !oq_clr |=> o_oq_valid;
  endproperty
  a_oq_read: assert property (p_oq_read) else $error("response not delivered");
  property p_oq_clear;
    @(posedge i_clk_sys) disable iff (i_rst)
    oq_clr && !i_oq_push |=> !o_msg_avail;
  endproperty
  a_oq_clear: assert property (p_oq_clear) else $error("output queue not cleared");
  property p_cls_keeps_oq;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_cls && !oq_clr && !i_oq_pop && o_msg_avail |=> o_msg_avail;
  endproperty
  a_cls_keeps_oq: assert property (p_cls_keeps_oq) else $error("cls hit output queue");
  property p_mav;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_msg_avail == (state_reg.oq_cnt != '0);
  endproperty
  a_mav: assert property (p_mav) else $error("message available wrong");
  property p_eq_read;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_err_pop && !eq_clr) ##1 !eq_clr |=> o_err_valid;
  endproperty
  a_eq_read: assert property (p_eq_read) else $error("error read unanswered");
  property p_ovf;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_err_push && !eq_clr && !i_err_pop && state_reg.eq_cnt == EQ_FULL
        |-> eq_we && eq_wa == state_reg.eq_wr - 1'b1 && eq_wd.num == seq_pkg::ERR_OVF_NUM
        ##1 state_reg.eq_cnt == EQ_FULL;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow entry wrong");
  property p_eq_keep;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_err_avail && !eq_clr && !i_err_pop |=> o_err_avail;
  endproperty
  a_eq_keep: assert property (p_eq_keep) else $error("error queue lost");
  property p_eav;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_err_avail == (state_reg.eq_cnt != '0);
  endproperty
  a_eav: assert property (p_eav) else $error("error available wrong");
  property p_summary;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_ext_summary == |(o_ext_event & state_reg.ese);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  // Main scenarios
  property p_cov_event;
    @(posedge i_clk_sys) disable iff (i_rst) $rose(o_ext_summary);
  endproperty
  c_cov_event: cover property (p_cov_event);
  property p_cov_ovf;
    @(posedge i_clk_sys) disable iff (i_rst) eq_ovf;
  endproperty
  c_cov_ovf: cover property (p_cov_ovf);
  property p_cov_oq_full;
    @(posedge i_clk_sys) disable iff (i_rst) o_oq_full ##2 o_oq_valid;
  endproperty
  c_cov_oq_full: cover property (p_cov_oq_full);

endmodule : seq_status

`default_nettype wire

//--- seq_host.sv
`default_nettype none

// Remote controller: reads one response byte or one error entry per call
module seq_host (
  // Clock
  input wire logic i_clk_sys,
  // Answers from the device
  input wire logic i_oq_valid,
  input wire logic [7:0] i_oq_data,
  input wire logic i_err_valid,
  input wire seq_pkg::seq_err_entry_t i_err_entry,
  // Read strobes
  output logic o_oq_pop,
  output logic o_err_pop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got;
  logic seen;

  initial begin
    o_oq_pop = 1'b0;
    o_err_pop = 1'b0;
  end

  // One strobe, then a bounded wait; valid lasts one cycle, so look every cycle
  task automatic fetch(input bit err);
    seen = 1'b0;
    got = 16'h0000;
    @(posedge i_clk_sys) #1;
    o_err_pop = err;
    o_oq_pop = !err;
    @(posedge i_clk_sys) #1;
    o_oq_pop = 1'b0;
    o_err_pop = 1'b0;
    for (int k = 0; k < 4 && !seen; k++) begin
      if (err ? i_err_valid : i_oq_valid) begin
        seen = 1'b1;
        got = err ? i_err_entry : {8'h00, i_oq_data};
      end
      if (!seen) @(posedge i_clk_sys) #1;
    end
  endtask : fetch
endmodule : seq_host

`default_nettype wire

//--- seq_tb.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, setchg = 1'b0, fwr = 1'b0, ese_wr = 1'b0, eer_rd = 1'b0;
  logic cls = 1'b0, oq_push = 1'b0, err_push = 1'b0;
  logic [7:0] pins = 8'h00, oq_d = 8'h00, oq_data;
  logic [4:0] fsuf = 5'h00;
  logic [3:0] clr = 4'h0;
  logic [15:0] ese = 16'h0000, cond, ev, exp_e;
  seq_pkg::seq_filt_mode_t fmode = seq_pkg::SEQ_NEVER;
  seq_pkg::seq_err_entry_t err_e = '0, err_out;
  logic summ, mav, eav, oq_valid, oq_full, err_valid, oq_pop, err_pop;
  int n_errors = 0, n_checks = 0;

  always #2.5 clk = ~clk;

  seq_status #(.SRC_CHG_CYCLES(20)) uut (.i_clk_sys(clk), .i_rst(rst), .i_output_on(pins[0]),
    .i_ext_junction_valid(pins[1]), .i_int_junction_valid(pins[2]),
    .i_amp_oscillating(pins[3]), .i_voltage_limiting(pins[4]),
    .i_current_limiting(pins[5]), .i_current_input_detected(pins[6]),
    .i_junction_sensor_connected(pins[7]), .i_setting_changed(setchg), .i_filt_wr(fwr),
    .i_filt_suffix(fsuf), .i_filt_mode(fmode), .i_ese_wr(ese_wr), .i_ese_data(ese),
    .i_eer_rd(eer_rd), .i_cls(cls), .i_msg_received(clr[0]), .i_deadlock(clr[1]),
    .i_dev_clear(clr[2]), .i_restart(clr[3]), .i_oq_push(oq_push), .i_oq_data(oq_d),
    .i_oq_pop(oq_pop), .o_oq_data(oq_data), .o_oq_valid(oq_valid), .o_oq_full(oq_full),
    .i_err_push(err_push), .i_err_entry(err_e), .i_err_pop(err_pop), .o_err_entry(err_out),
    .o_err_valid(err_valid), .o_condition(cond), .o_ext_event(ev), .o_ext_summary(summ),
    .o_msg_avail(mav), .o_err_avail(eav));

  seq_host host (.i_clk_sys(clk), .i_oq_valid(oq_valid), .i_oq_data(oq_data),
    .i_err_valid(err_valid), .i_err_entry(err_out), .o_oq_pop(oq_pop), .o_err_pop(err_pop));

  task automatic step();
    @(posedge clk) #1;
  endtask : step

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic set_filt(int s, seq_pkg::seq_filt_mode_t m);
    step();
    fwr = 1'b1;
    fsuf = s[4:0];
    fmode = m;
    step();
    fwr = 1'b0;
  endtask : set_filt

  // Pins up then down with a mix of filter modes; bit 6 stays in never mode
  task automatic t_cond();
    set_filt(2, seq_pkg::SEQ_RISE);
    set_filt(3, seq_pkg::SEQ_FALL);
    set_filt(5, seq_pkg::SEQ_BOTH);
    ese_wr = 1'b1;
    ese = 16'h0010;
    step();
    ese_wr = 1'b0;
    pins = 8'hff;
    repeat (8) step();
    chk("condition", 16'h07de, cond);
    chk("event", 16'h0012, ev);
    chk("summary", 16'h0001, 16'(summ));
    repeat (30) step();
    chk("condition", 16'h07d6, cond);
    setchg = 1'b1;
    step();
    setchg = 1'b0;
    repeat (4) step();
    chk("condition", 16'h07de, cond);
    eer_rd = 1'b1;
    step();
    eer_rd = 1'b0;
    step();
    chk("summary", 16'h0000, 16'(summ));
    pins = 8'h00;
    repeat (30) step();
    chk("event", 16'h0014, ev);
    // Suffix 21 is out of range and must not reach position 4
    set_filt(21, seq_pkg::SEQ_NEVER);
    set_filt(3, seq_pkg::SEQ_NEVER);
    step();
    chk("event", 16'h0010, ev);
    $display("test cond done");
  endtask : t_cond

  // Response bytes survive clear-status, then each clearing event empties the queue
  task automatic t_oq();
    for (int k = 0; k < 3; k++) begin
      step();
      oq_push = 1'b1;
      oq_d = 8'h5a + 8'(k);
    end
    step();
    oq_push = 1'b0;
    cls = 1'b1;
    step();
    cls = 1'b0;
    step();
    chk("msg avail", 16'h0001, 16'(mav));
    host.fetch(1'b0);
    chk("oq byte", 16'h005a, host.got);
    for (int k = 0; k < 4; k++) begin
      step();
      clr = 4'(1 << k);
      step();
      clr = 4'h0;
      step();
      chk("msg avail", 16'h0000, 16'(mav));
      oq_push = 1'b1;
      step();
      oq_push = 1'b0;
    end
    // One byte left over, then more pushes than slots: the surplus is dropped
    step();
    oq_d = 8'h11;
    oq_push = 1'b1;
    repeat (65) step();
    oq_push = 1'b0;
    step();
    chk("oq full", 16'h0001, 16'(oq_full));
    host.fetch(1'b0);
    chk("oq byte", 16'h005c, host.got);
    chk("oq full", 16'h0000, 16'(oq_full));
    $display("test oq done");
  endtask : t_oq

  // Nine entries into eight slots: the newest slot becomes the overflow entry
  task automatic t_eq();
    for (int k = 0; k < 9; k++) begin
      step();
      err_push = 1'b1;
      err_e = {10'(k + 113), 6'(k)};
    end
    step();
    err_push = 1'b0;
    clr = 4'h7;
    step();
    clr = 4'h0;
    step();
    chk("err avail", 16'h0001, 16'(eav));
    for (int k = 0; k < 8; k++) begin
      exp_e = (k < 7) ? {10'(k + 113), 6'(k)} : {seq_pkg::ERR_OVF_NUM, seq_pkg::ERR_OVF_MSG};
      host.fetch(1'b1);
      chk("err entry", exp_e, host.got);
    end
    step();
    chk("err avail", 16'h0000, 16'(eav));
    // Reading an empty queue still answers, with the no-error entry
    host.fetch(1'b1);
    chk("err none seen", 16'h0001, 16'(host.seen));
    chk("err none", {seq_pkg::ERR_NONE_NUM, seq_pkg::ERR_NONE_MSG}, host.got);
    err_push = 1'b1;
    step();
    err_push = 1'b0;
    chk("err avail", 16'h0001, 16'(eav));
    cls = 1'b1;
    step();
    cls = 1'b0;
    step();
    chk("err avail", 16'h0000, 16'(eav));
    $display("test eq done");
  endtask : t_eq

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_cond();
    t_oq();
    t_eq();
    give_verdict();
  end

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
